// file: rtl/fasg_pkg.sv
package fasg_pkg;

    // special-function register map: both registers share one address on different pages
    localparam logic [7:0]  SFR_ADDR_LIMIT     = 8'hB7;
    localparam logic [7:0]  SFR_PAGE_LIMIT     = 8'h0F;
    localparam logic [7:0]  SFR_ADDR_CTRL      = 8'hB7;
    localparam logic [7:0]  SFR_PAGE_CTRL      = 8'h00;
    localparam logic [7:0]  SFR_UNMAPPED_DATA  = 8'h00;

    localparam logic [7:0]  LIMIT_RESET        = 8'h00;
    localparam logic [7:0]  CTRL_RESET         = 8'h80;
    localparam logic [7:0]  CTRL_WRITE_MASK    = 8'hC1;
    localparam int          ONE_SHOT_BIT       = 7;
    localparam int          READ_ALWAYS_BIT    = 6;
    localparam int          FW_WE_BIT          = 0;
    localparam logic [7:0]  BOUNDARY_LOW_BYTE  = 8'h00;

    // program memory layout
    localparam logic [15:0] SEC_PAGE_BASE      = 16'hFA00;
    localparam logic [15:0] SEC_PAGE_LAST      = 16'hFBFF;
    localparam logic [15:0] WR_LOCK_ADDR       = 16'hFBFE;
    localparam logic [15:0] RD_LOCK_ADDR       = 16'hFBFF;
    localparam logic [15:0] RESERVED_BASE      = 16'hFC00;
    localparam logic [2:0]  SEC_PAGE_LOCK_BIT  = 3'h7;
    localparam int          BLOCK_MSB          = 15;
    localparam int          BLOCK_LSB          = 13;
    localparam logic [7:0]  DENIED_DATA        = 8'h00;

    typedef enum logic [1:0] {
        FASG_OP_FETCH = 2'b00,
        FASG_OP_READ  = 2'b01,
        FASG_OP_WRITE = 2'b10,
        FASG_OP_ERASE = 2'b11
    } fasg_op_t;

    typedef enum logic {
        FASG_SRC_DEBUG = 1'b0,
        FASG_SRC_FW    = 1'b1
    } fasg_src_t;

    typedef enum logic [2:0] {
        FASG_V_DENY       = 3'b000,
        FASG_V_READ       = 3'b001,
        FASG_V_ZERO       = 3'b010,
        FASG_V_WRITE      = 3'b011,
        FASG_V_PAGE_ERASE = 3'b100,
        FASG_V_FULL_ERASE = 3'b101
    } fasg_verdict_t;

endpackage : fasg_pkg

// file: rtl/fasg_access_check.sv
`timescale 1ns/1ns
module fasg_access_check #(
    parameter int ADDR_W = 16
) (
    input  wire logic                    src_i,
    input  wire logic [1:0]              op_i,
    input  wire logic [ADDR_W-1:0]       addr_i,
    input  wire logic [ADDR_W-1:0]       pc_i,
    input  wire logic [ADDR_W-1:0]       boundary_i,
    input  wire logic [7:0]              rd_lock_i,
    input  wire logic [7:0]              wr_lock_i,
    input  wire logic                    fw_we_i,
    output fasg_pkg::fasg_verdict_t      verdict_o
);

    if (ADDR_W != 16) begin : g_bad_width
        $error("fasg_access_check serves a 16-bit program space only");
    end

    logic       in_reserved;
    logic       in_sec_page;
    logic       is_lock_byte;
    logic [2:0] blk;
    logic       rd_open;
    logic       wr_open;
    logic       sec_open;
    logic       hidden;

    assign in_reserved  = addr_i >= fasg_pkg::RESERVED_BASE;
    assign in_sec_page  = (addr_i >= fasg_pkg::SEC_PAGE_BASE) && (addr_i <= fasg_pkg::SEC_PAGE_LAST);
    assign is_lock_byte = (addr_i == fasg_pkg::WR_LOCK_ADDR) || (addr_i == fasg_pkg::RD_LOCK_ADDR);
    assign blk          = addr_i[fasg_pkg::BLOCK_MSB:fasg_pkg::BLOCK_LSB];
    // lock bits are active low: a set bit leaves its 8 kB block open
    assign rd_open      = rd_lock_i[blk];
    assign wr_open      = wr_lock_i[blk];
    assign sec_open     = wr_lock_i[fasg_pkg::SEC_PAGE_LOCK_BIT];
    // code in the upper partition touching the lower one
    assign hidden       = (pc_i >= boundary_i) && (addr_i < boundary_i);

    always_comb begin
        verdict_o = fasg_pkg::FASG_V_DENY;
        if (!in_reserved) begin
            case (src_i)
                fasg_pkg::FASG_SRC_DEBUG: begin
                    case (op_i)
                        fasg_pkg::FASG_OP_FETCH,
                        fasg_pkg::FASG_OP_READ: begin
                            if (rd_open || is_lock_byte) begin
                                verdict_o = fasg_pkg::FASG_V_READ;
                            end
                        end
                        fasg_pkg::FASG_OP_WRITE: begin
                            if (wr_open || is_lock_byte) begin
                                verdict_o = fasg_pkg::FASG_V_WRITE;
                            end
                        end
                        default: begin
                            if (in_sec_page) begin
                                if (sec_open) begin
                                    verdict_o = fasg_pkg::FASG_V_PAGE_ERASE;
                                end else if (is_lock_byte) begin
                                    verdict_o = fasg_pkg::FASG_V_FULL_ERASE;
                                end
                            end else if (wr_open) begin
                                verdict_o = fasg_pkg::FASG_V_PAGE_ERASE;
                            end
                        end
                    endcase
                end
                default: begin
                    // lock bytes play no part for firmware
                    case (op_i)
                        fasg_pkg::FASG_OP_FETCH: begin
                            verdict_o = fasg_pkg::FASG_V_READ;
                        end
                        fasg_pkg::FASG_OP_READ: begin
                            verdict_o = hidden ? fasg_pkg::FASG_V_ZERO : fasg_pkg::FASG_V_READ;
                        end
                        fasg_pkg::FASG_OP_WRITE: begin
                            if (fw_we_i && !hidden) begin
                                verdict_o = fasg_pkg::FASG_V_WRITE;
                            end
                        end
                        default: begin
                            if (fw_we_i && !hidden && !in_sec_page) begin
                                verdict_o = fasg_pkg::FASG_V_PAGE_ERASE;
                            end
                        end
                    endcase
                end
            endcase
        end
    end

endmodule : fasg_access_check

// file: rtl/fasg_guard.sv
`timescale 1ns/1ns
// Notes on behaviour
// - boundary is limit byte over zero byte
// - boundary moves in 256-byte steps only
// - limit resets to zero, all readable
// - debug may access unlocked pages
// - debug blocked on locked pages
// - debug always reads and writes lock bytes
// - open security page erasable by debug
// - locked security page needs full erase
// - reserved area never accessible
// - firmware ignores lock bytes
// - lower firmware: all but security page erase
// - firmware never erases security page
// - upper firmware barred below the limit
// - upper code may fetch below limit
// - hidden code-space reads return zero
// - bit 7 enables read one-shot timer
module fasg_guard #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input  wire logic              ref_clk_i,
    input  wire logic              resetn_i,
    input  wire logic [7:0]        sfr_addr_i,
    input  wire logic [7:0]        sfr_page_i,
    input  wire logic              sfr_wr_i,
    input  wire logic              sfr_rd_i,
    input  wire logic [7:0]        sfr_wdata_i,
    output logic      [7:0]        sfr_rdata_o,
    output logic                   sfr_rvalid_o,
    input  wire logic              req_valid_i,
    input  wire logic              req_src_i,
    input  wire logic [1:0]        req_op_i,
    input  wire logic [ADDR_W-1:0] req_addr_i,
    input  wire logic [ADDR_W-1:0] req_pc_i,
    input  wire logic [DATA_W-1:0] req_wdata_i,
    input  wire logic [7:0]        read_lock_i,
    input  wire logic [7:0]        wr_lock_i,
    input  wire logic [DATA_W-1:0] flash_rdata_i,
    output logic                   flash_rd_o,
    output logic                   flash_wr_o,
    output logic                   flash_page_erase_o,
    output logic                   flash_full_erase_o,
    output logic      [ADDR_W-1:0] flash_addr_o,
    output logic      [DATA_W-1:0] flash_wdata_o,
    output logic                   resp_valid_o,
    output logic                   resp_denied_o,
    output logic      [DATA_W-1:0] resp_rdata_o,
    output logic      [ADDR_W-1:0] access_limit_boundary_o,
    output logic                   read_one_shot_enable_o,
    output logic                   read_always_enable_o,
    output logic                   firmware_write_erase_enable_o
);

    if (ADDR_W != 16 || DATA_W != 8) begin : g_bad_params
        $error("fasg_guard serves a 16-bit byte-wide program space only");
    end

    logic [7:0]              access_limit_high_byte;
    logic                    limit_locked;
    logic [7:0]              flash_timing_write_control;
    logic [ADDR_W-1:0]       access_limit_boundary;
    logic                    hit_limit;
    logic                    hit_ctrl;
    fasg_pkg::fasg_verdict_t verdict;
    fasg_pkg::fasg_verdict_t stage_verdict;
    logic                    stage_valid;

    assign hit_limit = (sfr_addr_i == fasg_pkg::SFR_ADDR_LIMIT) && (sfr_page_i == fasg_pkg::SFR_PAGE_LIMIT);
    assign hit_ctrl  = (sfr_addr_i == fasg_pkg::SFR_ADDR_CTRL) && (sfr_page_i == fasg_pkg::SFR_PAGE_CTRL);

    // low byte is always zero, so the boundary cannot fall inside a 256-byte step
    assign access_limit_boundary = {access_limit_high_byte, fasg_pkg::BOUNDARY_LOW_BYTE};

    // a rogue upper-partition loader must not be able to move the limit after the
    // protected code has set it, so every write after the first is dropped
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            access_limit_high_byte <= fasg_pkg::LIMIT_RESET;
            limit_locked           <= 1'b0;
        end else if (sfr_wr_i && hit_limit && !limit_locked) begin
            access_limit_high_byte <= sfr_wdata_i;
            limit_locked           <= 1'b1;
        end
    end

    // reserved bits 5..1 are held at zero
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_timing_write_control <= fasg_pkg::CTRL_RESET;
        end else if (sfr_wr_i && hit_ctrl) begin
            flash_timing_write_control <= sfr_wdata_i & fasg_pkg::CTRL_WRITE_MASK;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sfr_rdata_o  <= fasg_pkg::SFR_UNMAPPED_DATA;
            sfr_rvalid_o <= 1'b0;
        end else begin
            sfr_rvalid_o <= sfr_rd_i;
            if (sfr_rd_i && hit_limit) begin
                sfr_rdata_o <= access_limit_high_byte;
            end else if (sfr_rd_i && hit_ctrl) begin
                sfr_rdata_o <= flash_timing_write_control;
            end else begin
                sfr_rdata_o <= fasg_pkg::SFR_UNMAPPED_DATA;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            access_limit_boundary_o       <= {ADDR_W{1'b0}};
            read_one_shot_enable_o        <= fasg_pkg::CTRL_RESET[fasg_pkg::ONE_SHOT_BIT];
            read_always_enable_o          <= fasg_pkg::CTRL_RESET[fasg_pkg::READ_ALWAYS_BIT];
            firmware_write_erase_enable_o <= fasg_pkg::CTRL_RESET[fasg_pkg::FW_WE_BIT];
        end else begin
            access_limit_boundary_o       <= access_limit_boundary;
            read_one_shot_enable_o        <= flash_timing_write_control[fasg_pkg::ONE_SHOT_BIT];
            read_always_enable_o          <= flash_timing_write_control[fasg_pkg::READ_ALWAYS_BIT];
            firmware_write_erase_enable_o <= flash_timing_write_control[fasg_pkg::FW_WE_BIT];
        end
    end

    fasg_access_check #(
        .ADDR_W (ADDR_W)
    ) u_check (
        .src_i      (req_src_i),
        .op_i       (req_op_i),
        .addr_i     (req_addr_i),
        .pc_i       (req_pc_i),
        .boundary_i (access_limit_boundary),
        .rd_lock_i  (read_lock_i),
        .wr_lock_i  (wr_lock_i),
        .fw_we_i    (flash_timing_write_control[fasg_pkg::FW_WE_BIT]),
        .verdict_o  (verdict)
    );

    // stage 1: only granted verdicts reach the flash strobes
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            flash_rd_o         <= 1'b0;
            flash_wr_o         <= 1'b0;
            flash_page_erase_o <= 1'b0;
            flash_full_erase_o <= 1'b0;
            flash_addr_o       <= {ADDR_W{1'b0}};
            flash_wdata_o      <= {DATA_W{1'b0}};
            stage_valid        <= 1'b0;
            stage_verdict      <= fasg_pkg::FASG_V_DENY;
        end else begin
            flash_rd_o         <= req_valid_i && (verdict == fasg_pkg::FASG_V_READ);
            flash_wr_o         <= req_valid_i && (verdict == fasg_pkg::FASG_V_WRITE);
            flash_page_erase_o <= req_valid_i && (verdict == fasg_pkg::FASG_V_PAGE_ERASE);
            flash_full_erase_o <= req_valid_i && (verdict == fasg_pkg::FASG_V_FULL_ERASE);
            stage_valid        <= req_valid_i;
            if (req_valid_i) begin
                flash_addr_o  <= req_addr_i;
                flash_wdata_o <= req_wdata_i;
                stage_verdict <= verdict;
            end
        end
    end

    // stage 2: every request is answered, refused or not, so the core never hangs
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            resp_valid_o  <= 1'b0;
            resp_denied_o <= 1'b0;
            resp_rdata_o  <= {DATA_W{1'b0}};
        end else begin
            resp_valid_o  <= stage_valid;
            resp_denied_o <= stage_valid && (stage_verdict == fasg_pkg::FASG_V_DENY);
            if (stage_valid) begin
                if (stage_verdict == fasg_pkg::FASG_V_READ) begin
                    resp_rdata_o <= flash_rdata_i;
                end else begin
                    resp_rdata_o <= fasg_pkg::DENIED_DATA;
                end
            end
        end
    end

endmodule : fasg_guard

// file: dv/fasg_flash_model.sv
`timescale 1ns/1ns
module fasg_flash_model (
    input  wire logic        ref_clk_i,
    input  wire logic        flash_rd_i,
    input  wire logic [15:0] flash_addr_i,
    output logic      [7:0]  flash_rdata_o
);
    logic [7:0] last;
    // data is only good in the strobe cycle; otherwise it flips so a late sample reads garbage
    always_ff @(posedge ref_clk_i) last <= flash_rdata_o;
    assign flash_rdata_o = flash_rd_i ? (flash_addr_i[7:0] ^ 8'h3C) : ~last;
endmodule : fasg_flash_model

// file: dv/fasg_guard_chk.sv
`timescale 1ns/1ns
module fasg_guard_chk #(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input wire logic              ref_clk_i,
    input wire logic              resetn_i,
    input wire logic [7:0]        sfr_addr_i,
    input wire logic [7:0]        sfr_page_i,
    input wire logic              sfr_wr_i,
    input wire logic              req_valid_i,
    input wire logic              req_src_i,
    input wire logic [1:0]        req_op_i,
    input wire logic [ADDR_W-1:0] req_addr_i,
    input wire logic [ADDR_W-1:0] req_pc_i,
    input wire logic              flash_rd_o,
    input wire logic              flash_wr_o,
    input wire logic              flash_page_erase_o,
    input wire logic              flash_full_erase_o,
    input wire logic              resp_valid_o,
    input wire logic              resp_denied_o,
    input wire logic [DATA_W-1:0] resp_rdata_o,
    input wire logic [ADDR_W-1:0] access_limit_boundary_o,
    input wire logic              firmware_write_erase_enable_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    logic fw, up, wrs;
    assign fw  = req_valid_i && req_src_i;
    assign up  = req_pc_i >= access_limit_boundary_o && req_addr_i < access_limit_boundary_o;
    assign wrs = flash_wr_o || flash_page_erase_o || flash_full_erase_o;
    a_boundary_low: assert property (access_limit_boundary_o[7:0] == 8'h00)
        else $error("boundary low byte not zero");
    // the boundary output trails the limit register by one cycle, hence the depth of two
    a_limit_hold: assert property ($changed(access_limit_boundary_o) |->
        $past(sfr_wr_i && sfr_addr_i == 8'hB7 && sfr_page_i == 8'h0F, 2))
        else $error("boundary moved without a limit write");
    a_resp_two: assert property (req_valid_i |-> ##2 resp_valid_o) else $error("response not two cycles late");
    a_reserved_deny: assert property (req_valid_i && req_addr_i >= 16'hFC00 |=>
        !(wrs || flash_rd_o) ##1 resp_denied_o) else $error("reserved area reached");
    a_fw_sec_erase: assert property (fw && req_op_i == 2'b11 && req_addr_i[15:9] == 7'h7D |=>
        !wrs ##1 resp_denied_o) else $error("firmware erased security page");
    // the enable output lags the control register, so a control write just before is excluded
    a_fw_we_gate: assert property (fw && req_op_i[1] && !firmware_write_erase_enable_o &&
        !$past(sfr_wr_i && sfr_addr_i == 8'hB7 && sfr_page_i == 8'h00) |=> !wrs)
        else $error("firmware write while disabled");
    a_upper_zero: assert property (fw && req_op_i == 2'b01 && up |-> ##2 resp_rdata_o == 8'h00
        && !resp_denied_o) else $error("hidden read leaked data");
    a_upper_bar: assert property (fw && req_op_i[1] && up |=> !wrs ##1 resp_denied_o)
        else $error("upper code altered lower partition");
endmodule : fasg_guard_chk
bind fasg_guard fasg_guard_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) i_chk (.*);

// file: dv/tb_fasg_guard.sv
`timescale 1ns/1ns
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; $display("[ERR] %0t %h %h", $time, a, b); end end
module tb_fasg_guard;
    logic        ref_clk_i = 1'b0, resetn_i = 1'b0, sfr_wr_i = 1'b0, sfr_rd_i = 1'b0, sfr_rvalid_o;
    logic        req_valid_i = 1'b0, req_src_i = 1'b0, flash_rd_o, flash_wr_o, flash_page_erase_o;
    logic        flash_full_erase_o, resp_valid_o, resp_denied_o, read_one_shot_enable_o;
    logic        read_always_enable_o, firmware_write_erase_enable_o;
    logic [1:0]  req_op_i = 2'b00;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_page_i = 8'h00, sfr_wdata_i = 8'h00, read_lock_i = 8'hFF;
    logic [7:0]  wr_lock_i = 8'hFF, req_wdata_i = 8'h5A, flash_rdata_i, sfr_rdata_o, flash_wdata_o, resp_rdata_o;
    logic [15:0] req_addr_i = 16'h0000, req_pc_i = 16'h0000, flash_addr_o, access_limit_boundary_o;
    logic [3:0]  strobes;
    int          miscompares = 0, total_checks = 0, cycles = 0;
    fasg_guard i_dut (.*);
    fasg_flash_model i_flash (.ref_clk_i(ref_clk_i), .flash_rd_i(flash_rd_o), .flash_addr_i(flash_addr_o),
                              .flash_rdata_o(flash_rdata_i));
    initial forever #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            print_verdict();
        end
    end
    task automatic print_verdict;
        $display("checks %0d miscompares %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    // a read passes the expected byte in d
    task automatic sfr_acc(input logic wr, input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
        @(posedge ref_clk_i);
        sfr_wr_i    <= wr;
        sfr_rd_i    <= !wr;
        sfr_addr_i  <= a;
        sfr_page_i  <= p;
        sfr_wdata_i <= d;
        @(posedge ref_clk_i);
        sfr_wr_i <= 1'b0;
        sfr_rd_i <= 1'b0;
        #1;
        if (!wr) `CHK({sfr_rvalid_o, sfr_rdata_o}, {1'b1, d})
    endtask : sfr_acc
    // es is {rd, wr, page erase, full erase}; granted reads return the model's scrambled address
    task automatic req(input logic s, input logic [1:0] o, input logic [15:0] a, input logic [15:0] pc,
                       input logic [3:0] es, input logic ed);
        @(posedge ref_clk_i);
        req_valid_i <= 1'b1;
        req_src_i   <= s;
        req_op_i    <= o;
        req_addr_i  <= a;
        req_pc_i    <= pc;
        req_wdata_i <= a[7:0] ^ 8'hA5;
        @(posedge ref_clk_i);
        req_valid_i <= 1'b0;
        #1 strobes = {flash_rd_o, flash_wr_o, flash_page_erase_o, flash_full_erase_o};
        `CHK(strobes, es)
        `CHK({flash_addr_o, flash_wdata_o}, {a, a[7:0] ^ 8'hA5})
        @(posedge ref_clk_i);
        #1;
        `CHK({resp_valid_o, resp_denied_o, resp_rdata_o}, {1'b1, ed, es[3] ? a[7:0] ^ 8'h3C : 8'h00})
    endtask : req
    task automatic locks(input logic [7:0] r, input logic [7:0] w);
        @(posedge ref_clk_i);
        read_lock_i <= r;
        wr_lock_i   <= w;
    endtask : locks
    task automatic t_reset_ctrl;
        `CHK(access_limit_boundary_o, 16'h0000)
        sfr_acc(1'b0, 8'hB7, 8'h00, 8'h80);
        sfr_acc(1'b0, 8'h10, 8'h00, 8'h00);
        sfr_acc(1'b1, 8'hB7, 8'h00, 8'hFF);
        sfr_acc(1'b0, 8'hB7, 8'h00, 8'hC1);
        `CHK({read_one_shot_enable_o, read_always_enable_o, firmware_write_erase_enable_o}, 3'b111)
        sfr_acc(1'b1, 8'hB7, 8'h00, 8'h00);
        // the level outputs follow the control register one edge later
        @(posedge ref_clk_i);
        #1;
        `CHK({read_one_shot_enable_o, read_always_enable_o, firmware_write_erase_enable_o}, 3'b000)
    endtask : t_reset_ctrl
    task automatic t_limit;
        sfr_acc(1'b0, 8'hB7, 8'h0F, 8'h00);
        sfr_acc(1'b1, 8'hB7, 8'h0F, 8'h42);
        @(posedge ref_clk_i);
        #1;
        `CHK(access_limit_boundary_o, 16'h4200)
        sfr_acc(1'b1, 8'hB7, 8'h0F, 8'h80);
        `CHK(access_limit_boundary_o, 16'h4200)
        sfr_acc(1'b0, 8'hB7, 8'h0F, 8'h42);
    endtask : t_limit
    task automatic t_debug;
        locks(8'hFD, 8'hFB);
        req(1'b0, 2'b01, 16'h2000, 16'h0000, 4'h0, 1'b1);
        req(1'b0, 2'b01, 16'h0010, 16'h0000, 4'h8, 1'b0);
        req(1'b0, 2'b00, 16'h0020, 16'h0000, 4'h8, 1'b0);
        req(1'b0, 2'b00, 16'h2020, 16'h0000, 4'h0, 1'b1);
        req(1'b0, 2'b10, 16'h4000, 16'h0000, 4'h0, 1'b1);
        req(1'b0, 2'b11, 16'h0200, 16'h0000, 4'h2, 1'b0);
        req(1'b0, 2'b01, 16'hFC10, 16'h0000, 4'h0, 1'b1);
        req(1'b0, 2'b11, 16'hFA10, 16'h0000, 4'h2, 1'b0);
        locks(8'h00, 8'h7B);
        req(1'b0, 2'b01, 16'hFBFF, 16'h0000, 4'h8, 1'b0);
        req(1'b0, 2'b10, 16'hFBFE, 16'h0000, 4'h4, 1'b0);
        req(1'b0, 2'b11, 16'hFA10, 16'h0000, 4'h0, 1'b1);
        req(1'b0, 2'b11, 16'hFBFE, 16'h0000, 4'h1, 1'b0);
    endtask : t_debug
    task automatic t_firmware;
        req(1'b1, 2'b10, 16'h9000, 16'h8000, 4'h0, 1'b1);
        sfr_acc(1'b1, 8'hB7, 8'h00, 8'h81);
        req(1'b1, 2'b01, 16'h2000, 16'h1000, 4'h8, 1'b0);
        req(1'b1, 2'b10, 16'h2000, 16'h1000, 4'h4, 1'b0);
        req(1'b1, 2'b11, 16'hFA00, 16'h1000, 4'h0, 1'b1);
        req(1'b1, 2'b10, 16'hFBFE, 16'h8000, 4'h4, 1'b0);
        req(1'b1, 2'b01, 16'h41FF, 16'h4200, 4'h0, 1'b0);
        req(1'b1, 2'b01, 16'h4200, 16'h4200, 4'h8, 1'b0);
        req(1'b1, 2'b10, 16'h1000, 16'h8000, 4'h0, 1'b1);
        req(1'b1, 2'b11, 16'h9000, 16'h8000, 4'h2, 1'b0);
        req(1'b1, 2'b00, 16'h1000, 16'h8000, 4'h8, 1'b0);
        req(1'b1, 2'b01, 16'hFC00, 16'h1000, 4'h0, 1'b1);
    endtask : t_firmware
    task automatic t_rereset;
        @(posedge ref_clk_i);
        resetn_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        sfr_acc(1'b0, 8'hB7, 8'h00, 8'h80);
        sfr_acc(1'b1, 8'hB7, 8'h0F, 8'h10);
        @(posedge ref_clk_i);
        #1;
        `CHK(access_limit_boundary_o, 16'h1000)
    endtask : t_rereset
    initial begin
        repeat (5) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        t_reset_ctrl();
        t_limit();
        t_debug();
        t_firmware();
        t_rereset();
        print_verdict();
    end
endmodule : tb_fasg_guard
